// *** cgen_pkg.sv ***
// Constants, register map and carrier types of the system clock generator.
// Assumes a single 40 MHz system clock and an APB register port.
//
// Contract
// R1: Provide main clock for CPU, subsystem clock and crystal-derived aux clock.
// R2: After reset, main clock from internal oscillator, resistor select clear, nominal tap.
// R3: Failed crystal feeding the main clock forces the main clock onto the oscillator.
// R4: Subsystem clock from crystal or oscillator; aux clock always from crystal.
// R5: Crystal oscillator offers low-frequency, high-frequency and external input modes.
// R6: Crystal starts at power-up; with disable set it stops unless feeding main clock.
// R7: Aux and subsystem clocks can be routed out through port pins.
// R8: Oscillator rate set by external or eight internal resistors, then tap and modulation.
// R9: Internal oscillator stops whenever neither CPU nor peripherals use it.
// R10: Generator-off bit shuts down the oscillator dc generator to save power.
// R11: Fault, reset-pin and flash-violation flags share one NMI; sticky until cleared.
// R12: Oscillator fault flag set by the same detection that drives fail-safe switching.
package cgen_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CGEN_CLK_MHZ = 40;
  // Silence on the crystal before declaring it failed (least times)
  localparam int CGEN_LF_FAULT_NS = 200000;
  localparam int CGEN_HF_FAULT_NS = 10000;
  localparam int CGEN_LF_FAULT_CYC = (CGEN_LF_FAULT_NS * CGEN_CLK_MHZ + 999) / 1000;
  localparam int CGEN_HF_FAULT_CYC = (CGEN_HF_FAULT_NS * CGEN_CLK_MHZ + 999) / 1000;
  localparam int CGEN_FCW = 16;

  // ----------------------------------------------------------------
  // Oscillator divider figures
  // ----------------------------------------------------------------
  localparam int CGEN_HW = 6;
  localparam logic [5:0] CGEN_HALF_INT = 6'h10;
  localparam logic [5:0] CGEN_HALF_EXT = 6'h0C;
  localparam logic [2:0] CGEN_STEP_MAX = 3'h7;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CGEN_OFS_DCO = 8'h00;
  localparam logic [7:0] CGEN_OFS_CTRL1 = 8'h04;
  localparam logic [7:0] CGEN_OFS_CTRL2 = 8'h08;
  localparam logic [7:0] CGEN_OFS_STAT = 8'h0C;
  localparam logic [7:0] CGEN_OFS_MASK = 8'h10;
  localparam logic [7:0] CGEN_OFS_LIVE = 8'h14;

  typedef enum logic [1:0] {CGEN_XT_LF, CGEN_XT_HF, CGEN_XT_EXT} cgen_xmode_type;

  typedef struct packed {
    logic [2:0] tap;
    logic [4:0] modulation;
  } cgen_dco_type;

  typedef struct packed {
    cgen_xmode_type xmode;
    logic [2:0] rsel;
  } cgen_ctrl1_type;

  typedef struct packed {
    logic sub_pin_en;
    logic aux_pin_en;
    logic dc_generator_off;
    logic crystal_osc_disable;
    logic external_resistor_select;
    logic sub_sel_crystal;
    logic main_sel_crystal;
  } cgen_ctrl2_type;

  typedef struct packed {
    logic flash_access_violation_flag;
    logic reset_pin_interrupt_flag;
    logic osc_fault_flag;
  } cgen_flags_type;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam cgen_dco_type CGEN_DCO_RST = 8'h60;
  localparam cgen_ctrl1_type CGEN_CTRL1_RST = 5'h04;
  localparam cgen_ctrl2_type CGEN_CTRL2_RST = 7'h00;
  localparam cgen_flags_type CGEN_FLAGS_RST = 3'h0;

endpackage

// *** cgen_fault_det.sv ***
// Crystal activity monitor: flags a failure after too long without an edge.
// Assumes the crystal level arrives already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module cgen_fault_det
  import cgen_pkg::*;
#(
  parameter int LF_CYC = CGEN_LF_FAULT_CYC,
  parameter int HF_CYC = CGEN_HF_FAULT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Monitored crystal
  input wire logic xtal_lvl,
  input wire logic run,
  input wire logic short_limit,
  // Result
  output logic fault_q
);

  logic [CGEN_FCW-1:0] cnt_q;
  logic prev_q;
  logic [CGEN_FCW-1:0] limit;

  if (LF_CYC < 2 || HF_CYC < 2 || LF_CYC >= 2**CGEN_FCW || HF_CYC >= 2**CGEN_FCW) begin : g_chk
    $error("cgen_fault_det: fault limits out of range");
  end

  // Low-frequency crystals are slow, so they get the longer limit
  assign limit = short_limit ? CGEN_FCW'(HF_CYC) : CGEN_FCW'(LF_CYC);

  // Edge watchdog; a stopped oscillator is not reported as failed
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= '0;
      prev_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      prev_q <= xtal_lvl;
      if (!run || (xtal_lvl != prev_q)) begin
        cnt_q <= '0;
        fault_q <= 1'b0;
      end else if (cnt_q >= limit - CGEN_FCW'(1)) begin
        fault_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + CGEN_FCW'(1);
      end
    end
  end

endmodule
`default_nettype wire

// *** cgen_dco.sv ***
// Digitally controlled oscillator model: a half-period divider of clk with modulation.
// Assumes the half-period is recomputed by the caller from resistor and tap settings.
`timescale 1ns/1ps
`default_nettype none
module cgen_dco
  import cgen_pkg::*;
#(
  parameter int HW = CGEN_HW
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic en,
  input wire logic [HW-1:0] half,
  input wire logic [4:0] modulation,
  // Oscillator output level
  output logic dco_q
);

  logic [HW-1:0] cnt_q;
  logic [4:0] slot_q;
  logic [HW-1:0] target;

  if (HW < 3) begin : g_chk
    $error("cgen_dco: half-period width too small");
  end

  // Stretch some half-periods by one cycle to reach in-between rates
  assign target = (slot_q < modulation) ? half : half - HW'(1);

  // Divider stops dead when disabled, output parked low
  always_ff @(posedge clk) begin
    if (!nrst || !en) begin
      cnt_q <= '0;
      slot_q <= '0;
      dco_q <= 1'b0;
    end else if (cnt_q >= target) begin
      cnt_q <= '0;
      slot_q <= slot_q + 5'h01;
      dco_q <= !dco_q;
    end else begin
      cnt_q <= cnt_q + HW'(1);
    end
  end

endmodule
`default_nettype wire

// *** cgen_top.sv ***
// System clock generator: main, subsystem and auxiliary clocks with crystal fail-safe.
// Assumes APB on clk, a crystal level on a pin and same-clock event pulses from
// the reset-pin and flash logic. Clock outputs are levels sampled on clk.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cgen_top
  import cgen_pkg::*;
#(
  parameter int LF_FAULT_CYC = CGEN_LF_FAULT_CYC,
  parameter int HF_FAULT_CYC = CGEN_HF_FAULT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Crystal oscillator pins
  input wire logic crystal_osc_clock_pin,
  output logic xtal_drive_en,
  output logic xtal_hf_mode,
  // System requests and events
  input wire logic cpu_off,
  input wire logic periph_dco_request,
  input wire logic reset_pin_event,
  input wire logic flash_access_violation_event,
  // Generated clocks
  output logic main_clock,
  output logic subsystem_clock,
  output logic aux_clock,
  output logic dc_gen_on,
  // Port pin routing
  output logic aux_pin_o,
  output logic aux_pin_oe,
  output logic sub_pin_o,
  output logic sub_pin_oe,
  // Shared non-maskable interrupt
  output logic nmi_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cgen_dco_type dco_q;
  cgen_ctrl1_type ctrl1_q;
  cgen_ctrl2_type ctrl2_q;
  cgen_flags_type flags_q;
  cgen_flags_type flags_d;
  cgen_flags_type mask_q;
  logic xs1_q;
  logic xs2_q;
  logic fault;
  logic dco_lvl;
  logic dco_en_q;
  logic xtal_run;
  logic xtal_lvl;
  logic main_uses_xtal;
  logic dco_need;
  logic [CGEN_HW-1:0] dco_half;
  logic [31:0] rd_mux;
  logic addr_hit;
  logic setup;
  logic access;
  logic wr;
  logic rd_stat;

  // ----------------------------------------------------------------
  // Crystal input synchroniser and monitor
  // ----------------------------------------------------------------
  // Pin is asynchronous to clk; only the second stage is read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      xs1_q <= 1'b0;
      xs2_q <= 1'b0;
    end else begin
      xs1_q <= crystal_osc_clock_pin;
      xs2_q <= xs1_q;
    end
  end

  // Oscillator keeps running while picked for the main clock, even when failing,
  // so that it can recover
  assign xtal_run = !ctrl2_q.crystal_osc_disable || ctrl2_q.main_sel_crystal; // [R6]
  assign xtal_lvl = xs2_q && xtal_run;

  cgen_fault_det #(
    .LF_CYC(LF_FAULT_CYC),
    .HF_CYC(HF_FAULT_CYC)
  ) u_fault (
    .clk(clk),
    .nrst(nrst),
    .xtal_lvl(xs2_q),
    .run(xtal_run),
    .short_limit(ctrl1_q.xmode != CGEN_XT_LF), // [R5]
    .fault_q(fault)
  );

  // ----------------------------------------------------------------
  // Internal oscillator
  // ----------------------------------------------------------------
  // Base from resistor choice, then one of eight resistor steps, then the tap
  assign dco_half = (ctrl2_q.external_resistor_select ? CGEN_HALF_EXT : CGEN_HALF_INT)
                  + CGEN_HW'({(CGEN_STEP_MAX - ctrl1_q.rsel), 1'b0})
                  + CGEN_HW'(CGEN_STEP_MAX - dco_q.tap); // [R8]

  // Fail-safe: a failed crystal never drives the main clock
  assign main_uses_xtal = ctrl2_q.main_sel_crystal && !fault; // [R3]

  // Oscillator runs only with a live consumer and the generator powered
  assign dco_need = !ctrl2_q.dc_generator_off
                  && ((!main_uses_xtal && !cpu_off)
                      || (!ctrl2_q.sub_sel_crystal && periph_dco_request)); // [R9] [R10]

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dco_en_q <= 1'b0;
      dc_gen_on <= 1'b0;
    end else begin
      dco_en_q <= dco_need; // [R9]
      dc_gen_on <= !ctrl2_q.dc_generator_off; // [R10]
    end
  end

  cgen_dco #(
    .HW(CGEN_HW)
  ) u_dco (
    .clk(clk),
    .nrst(nrst),
    .en(dco_en_q),
    .half(dco_half),
    .modulation(dco_q.modulation), // [R8]
    .dco_q(dco_lvl)
  );

  // ----------------------------------------------------------------
  // Clock outputs and pin routing
  // ----------------------------------------------------------------
  // Registered muxes; a switch may shorten one phase, a tolerated trade for size
  always_ff @(posedge clk) begin
    if (!nrst) begin
      main_clock <= 1'b0;
      subsystem_clock <= 1'b0;
      aux_clock <= 1'b0;
    end else begin
      main_clock <= !cpu_off && (main_uses_xtal ? xtal_lvl : dco_lvl); // [R1] [R3]
      subsystem_clock <= ctrl2_q.sub_sel_crystal ? xtal_lvl : dco_lvl; // [R4]
      aux_clock <= xtal_lvl; // [R4]
    end
  end

  // Port pins mirror the same source levels as the internal clocks
  always_ff @(posedge clk) begin
    if (!nrst) begin
      aux_pin_o <= 1'b0;
      aux_pin_oe <= 1'b0;
      sub_pin_o <= 1'b0;
      sub_pin_oe <= 1'b0;
    end else begin
      aux_pin_oe <= ctrl2_q.aux_pin_en; // [R7]
      aux_pin_o <= ctrl2_q.aux_pin_en && xtal_lvl;
      sub_pin_oe <= ctrl2_q.sub_pin_en; // [R7]
      sub_pin_o <= ctrl2_q.sub_pin_en && (ctrl2_q.sub_sel_crystal ? xtal_lvl : dco_lvl);
    end
  end

  // Crystal amplifier controls
  always_ff @(posedge clk) begin
    if (!nrst) begin
      xtal_drive_en <= 1'b1;
      xtal_hf_mode <= 1'b0;
    end else begin
      xtal_drive_en <= xtal_run && (ctrl1_q.xmode != CGEN_XT_EXT); // [R5] [R6]
      xtal_hf_mode <= ctrl1_q.xmode == CGEN_XT_HF; // [R5]
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr = access && pwrite && !pslverr;
  assign rd_stat = access && !pwrite && !pslverr && (paddr == CGEN_OFS_STAT);

  // Read data and decode of the addressed word
  always_comb begin
    rd_mux = 32'h00000000;
    addr_hit = 1'b1;
    case (paddr)
      CGEN_OFS_DCO: rd_mux = 32'(dco_q);
      CGEN_OFS_CTRL1: rd_mux = 32'(ctrl1_q);
      CGEN_OFS_CTRL2: rd_mux = 32'(ctrl2_q);
      CGEN_OFS_STAT: rd_mux = 32'(flags_q);
      CGEN_OFS_MASK: rd_mux = 32'(mask_q);
      CGEN_OFS_LIVE: rd_mux = 32'({dco_en_q, xtal_run, fault, main_uses_xtal});
      default: addr_hit = 1'b0;
    endcase
  end

  // One access cycle always; data captured in setup so it holds through access
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= !addr_hit;
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dco_q <= CGEN_DCO_RST; // [R2]
      ctrl1_q <= CGEN_CTRL1_RST;
      ctrl2_q <= CGEN_CTRL2_RST; // [R2]
      mask_q <= CGEN_FLAGS_RST;
    end else if (wr) begin
      case (paddr)
        CGEN_OFS_DCO: dco_q <= pwdata[$bits(cgen_dco_type)-1:0];
        CGEN_OFS_CTRL1: begin
          // The unused mode code falls back to the low-frequency mode
          if (pwdata[4:3] == 2'h3) begin
            ctrl1_q <= {CGEN_XT_LF, pwdata[2:0]};
          end else begin
            ctrl1_q <= pwdata[$bits(cgen_ctrl1_type)-1:0]; // [R5]
          end
        end
        CGEN_OFS_CTRL2: ctrl2_q <= pwdata[$bits(cgen_ctrl2_type)-1:0];
        CGEN_OFS_MASK: mask_q <= pwdata[$bits(cgen_flags_type)-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags and shared interrupt
  // ----------------------------------------------------------------
  // A status read clears, but an event in the same cycle wins
  always_comb begin
    flags_d = rd_stat ? CGEN_FLAGS_RST : flags_q; // [R11]
    flags_d.osc_fault_flag = flags_d.osc_fault_flag || fault; // [R12]
    flags_d.reset_pin_interrupt_flag = flags_d.reset_pin_interrupt_flag || reset_pin_event;
    flags_d.flash_access_violation_flag = flags_d.flash_access_violation_flag
                                        || flash_access_violation_event;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags_q <= CGEN_FLAGS_RST;
      nmi_irq <= 1'b0;
    end else begin
      flags_q <= flags_d;
      nmi_irq <= |(flags_d & mask_q); // [R11]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_reset_defaults;
    @(posedge clk) $rose(nrst) |-> (!ctrl2_q.main_sel_crystal
      && !ctrl2_q.external_resistor_select && dco_q == CGEN_DCO_RST);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) // [R2]
    else $error("reset defaults wrong");

  property p_failsafe;
    @(posedge clk) disable iff (!nrst)
      (fault && !cpu_off) ##1 !cpu_off |-> main_clock == $past(dco_lvl);
  endproperty
  a_failsafe: assert property (p_failsafe) // [R3]
    else $error("main clock not on oscillator after crystal fault");

  property p_aux_from_crystal;
    @(posedge clk) disable iff (!nrst)
      ##1 aux_clock == $past(xs2_q && xtal_run);
  endproperty
  a_aux_from_crystal: assert property (p_aux_from_crystal) // [R4]
    else $error("aux clock not following crystal");

  property p_crystal_stop;
    @(posedge clk) disable iff (!nrst)
      (ctrl2_q.crystal_osc_disable && !ctrl2_q.main_sel_crystal)[*2] |-> !xtal_drive_en && !aux_clock;
  endproperty
  a_crystal_stop: assert property (p_crystal_stop) // [R6]
    else $error("crystal still running while disabled");

  property p_pin_route;
    @(posedge clk) disable iff (!nrst)
      aux_pin_oe |-> aux_pin_o == aux_clock;
  endproperty
  a_pin_route: assert property (p_pin_route) // [R7]
    else $error("aux pin differs from aux clock");

  property p_dco_stop;
    @(posedge clk) disable iff (!nrst)
      !dco_need ##1 !dco_need |=> !dco_lvl;
  endproperty
  a_dco_stop: assert property (p_dco_stop) // [R9]
    else $error("oscillator running without a consumer");

  property p_gen_off;
    @(posedge clk) disable iff (!nrst)
      ctrl2_q.dc_generator_off |=> !dc_gen_on && !dco_en_q;
  endproperty
  a_gen_off: assert property (p_gen_off) // [R10]
    else $error("generator on while switched off");

  property p_flag_sticky;
    @(posedge clk) disable iff (!nrst)
      (flags_q.reset_pin_interrupt_flag && !rd_stat) |=> flags_q.reset_pin_interrupt_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // [R11]
    else $error("flag lost without a read");

  property p_fault_flag;
    @(posedge clk) disable iff (!nrst)
      fault |=> flags_q.osc_fault_flag && (nmi_irq || !$past(mask_q.osc_fault_flag));
  endproperty
  a_fault_flag: assert property (p_fault_flag) // [R12]
    else $error("fault did not raise its flag");

endmodule
`default_nettype wire

// *** cgen_xtal_model.sv ***
// Crystal, resonator or external clock source seen at the crystal pin.
// Assumes the bench clock paces it and the bench decides when it dies.
`timescale 1ns/1ps
`default_nettype none
module cgen_xtal_model #(
  parameter int HALF = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Amplifier and source control
  input wire logic drive_en,
  input wire logic ext_src,
  input wire logic stuck,
  // Crystal level
  output logic lvl
);
  // ----------------------------------------------------------------
  // Oscillation
  // ----------------------------------------------------------------
  int cnt;

  // Dead or unpowered crystal sits low, so no edge can hide a fault
  always_ff @(posedge clk) begin
    if (!nrst || stuck || !(drive_en || ext_src)) begin
      cnt <= 0;
      lvl <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      lvl <= !lvl;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// *** cgen_tb_top.sv ***
// Self-checking bench of the clock generator, with a crystal model.
// Assumes short fault limits (20/8 cycles) and a crystal half period of 5 cycles.
`timescale 1ns/1ps
`default_nettype none
module cgen_tb_top;
  import cgen_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, xlvl, xtal_drive_en, xtal_hf_mode, nmi_irq, dc_gen_on;
  logic cpu_off = 1'b0, periph = 1'b0, rpe = 1'b0, fve = 1'b0, stuck = 1'b0, ext = 1'b0;
  logic main_clock, subsystem_clock, aux_clock, aux_pin_o, aux_pin_oe, sub_pin_o, sub_pin_oe;
  int mismatches = 0;
  int checks_done = 0;

  cgen_top #(.LF_FAULT_CYC(20), .HF_FAULT_CYC(8)) i_dut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_osc_clock_pin(xlvl), .xtal_drive_en(xtal_drive_en), .xtal_hf_mode(xtal_hf_mode),
    .cpu_off(cpu_off), .periph_dco_request(periph), .reset_pin_event(rpe),
    .flash_access_violation_event(fve), .main_clock(main_clock),
    .subsystem_clock(subsystem_clock), .aux_clock(aux_clock), .dc_gen_on(dc_gen_on),
    .aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe), .sub_pin_o(sub_pin_o),
    .sub_pin_oe(sub_pin_oe), .nmi_irq(nmi_irq));

  cgen_xtal_model #(.HALF(5)) i_xtal (
    .clk(clk), .nrst(nrst), .drive_en(xtal_drive_en), .ext_src(ext), .stuck(stuck), .lvl(xlvl));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Reporting and compares
  // ----------------------------------------------------------------
  task automatic test_done();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic bad(input string m);
    mismatches++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) bad(m);
  endtask

  task automatic chk1(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp) bad(m);
  endtask

  // Counts are bench-made, so plain int ranges suffice
  task automatic chkn(input int got, input int lo, input int hi, input string m);
    checks_done++;
    if (got < lo || got > hi) bad(m);
  endtask

  // ----------------------------------------------------------------
  // Bus and observation helpers
  // ----------------------------------------------------------------
  // One APB transfer; holds everything until pready is seen at an edge
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad("bus hang");
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk32(rd, e, m);
  endtask

  // Poll a status bit; a bound keeps a dead design from hanging the run
  task automatic live(input int b, input logic e, input string m);
    int n;
    n = 0;
    do begin
      apb(1'b0, CGEN_OFS_LIVE, 32'h0);
      n++;
    end while (rd[b] !== e && n < 40);
    chk1(rd[b], e, m);
    if (rd[b] !== e) test_done();
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return main_clock;
      1: return subsystem_clock;
      2: return aux_clock;
      3: return sub_pin_o;
      default: return aux_pin_o;
    endcase
  endfunction

  task automatic tg(input int s, input int n, output int c);
    logic p;
    c = 0;
    p = pick(s);
    repeat (n) begin
      @(negedge clk);
      if (pick(s) !== p) c++;
      p = pick(s);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    @(negedge clk);
    chk1(xtal_drive_en, 1'b1, "crystal off at start");
    rdchk(CGEN_OFS_DCO, 32'h60, "dco reset");
    rdchk(CGEN_OFS_CTRL1, 32'h04, "ctrl1 reset");
    rdchk(CGEN_OFS_CTRL2, 32'h00, "ctrl2 reset");
    rdchk(CGEN_OFS_MASK, 32'h00, "mask reset");
    rdchk(CGEN_OFS_LIVE, 32'h0C, "main not on oscillator");
  endtask

  task automatic t_regs();
    wr(CGEN_OFS_DCO, 32'hA5);
    rdchk(CGEN_OFS_DCO, 32'hA5, "dco write");
    wr(CGEN_OFS_CTRL1, 32'h1F);
    rdchk(CGEN_OFS_CTRL1, 32'h07, "resistor select");
    wr(CGEN_OFS_DCO, 32'h60);
    wr(CGEN_OFS_CTRL1, 32'h04);
    apb(1'b1, 8'h18, 32'hFF);
    chk1(err, 1'b1, "unmapped write");
    apb(1'b0, 8'h18, 32'h0);
    chk32({rd[31:1], err}, 32'h1, "unmapped read");
  endtask

  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      wr(CGEN_OFS_CTRL1, {27'h0, m[1:0], 3'h4});
      ext <= (m == 2);
      repeat (2) @(negedge clk);
      chk1(xtal_hf_mode, m == 1, "mode pin");
      chk1(xtal_drive_en, m != 2, "amplifier");
    end
    live(1, 1'b0, "external source faults");
    wr(CGEN_OFS_CTRL1, 32'h04);
    ext <= 1'b0;
  endtask

  task automatic t_failsafe();
    int c;
    wr(CGEN_OFS_MASK, 32'h1);
    wr(CGEN_OFS_CTRL2, 32'h1);
    live(0, 1'b1, "main not on crystal");
    tg(0, 40, c);
    chkn(c, 6, 10, "main not crystal rate");
    stuck <= 1'b1;
    live(1, 1'b1, "fault not seen");
    live(0, 1'b0, "no fail-safe switch");
    tg(0, 120, c);
    chkn(c, 3, 6, "main not oscillator rate");
    chk1(nmi_irq, 1'b1, "no nmi on fault");
    wr(CGEN_OFS_MASK, 32'h0);
    repeat (2) @(negedge clk);
    chk1(nmi_irq, 1'b0, "masked nmi");
    wr(CGEN_OFS_MASK, 32'h1);
    stuck <= 1'b0;
    live(1, 1'b0, "fault stuck");
    live(0, 1'b1, "main not back");
    rdchk(CGEN_OFS_STAT, 32'h1, "fault flag lost");
    rdchk(CGEN_OFS_STAT, 32'h0, "fault flag kept");
    @(negedge clk);
    chk1(nmi_irq, 1'b0, "nmi after clear");
    wr(CGEN_OFS_CTRL2, 32'h0);
  endtask

  task automatic t_events();
    wr(CGEN_OFS_MASK, 32'h0);
    rpe <= 1'b1;
    @(posedge clk);
    rpe <= 1'b0;
    repeat (3) @(negedge clk);
    chk1(nmi_irq, 1'b0, "masked event nmi");
    @(posedge clk);
    fve <= 1'b1;
    @(posedge clk);
    fve <= 1'b0;
    wr(CGEN_OFS_MASK, 32'h6);
    repeat (2) @(negedge clk);
    chk1(nmi_irq, 1'b1, "shared nmi");
    rdchk(CGEN_OFS_STAT, 32'h6, "event flags");
    repeat (2) @(negedge clk);
    chk1(nmi_irq, 1'b0, "nmi after read");
    rdchk(CGEN_OFS_STAT, 32'h0, "flags not cleared");
  endtask

  task automatic t_disable();
    int c;
    wr(CGEN_OFS_CTRL2, 32'h8);
    repeat (6) @(negedge clk);
    chk1(xtal_drive_en, 1'b0, "disabled crystal runs");
    tg(2, 30, c);
    chkn(c, 0, 0, "aux without crystal");
    rdchk(CGEN_OFS_LIVE, 32'h8, "stopped crystal state");
    wr(CGEN_OFS_CTRL2, 32'h9);
    repeat (2) @(negedge clk);
    chk1(xtal_drive_en, 1'b1, "main crystal stopped");
    wr(CGEN_OFS_CTRL2, 32'h0);
  endtask

  task automatic t_routes();
    int c;
    wr(CGEN_OFS_CTRL2, 32'h62);
    repeat (2) @(negedge clk);
    chk1(aux_pin_oe, 1'b1, "aux pin idle");
    chk1(sub_pin_oe, 1'b1, "sub pin idle");
    tg(3, 100, c);
    chkn(c, 15, 25, "sub pin not crystal");
    tg(4, 100, c);
    chkn(c, 15, 25, "aux pin not crystal");
    wr(CGEN_OFS_CTRL2, 32'h0);
    tg(1, 100, c);
    chkn(c, 2, 6, "sub not oscillator");
    chk1(aux_pin_oe | sub_pin_oe, 1'b0, "pins still driven");
  endtask

  // Rate of the oscillator with internal and external resistor, fastest steps
  task automatic t_osc();
    int c;
    wr(CGEN_OFS_DCO, 32'hE0);
    wr(CGEN_OFS_CTRL1, 32'h07);
    for (int x = 0; x < 2; x++) begin
      wr(CGEN_OFS_CTRL2, {29'h0, x[0], 2'h0});
      repeat (30) @(negedge clk);
      tg(1, 96, c);
      chkn(c, 6 + 2 * x, 6 + 2 * x, "oscillator rate");
    end
    wr(CGEN_OFS_CTRL2, 32'h0);
    wr(CGEN_OFS_DCO, 32'h60);
    wr(CGEN_OFS_CTRL1, 32'h04);
  endtask

  task automatic t_dco();
    int c;
    @(posedge clk);
    cpu_off <= 1'b1;
    repeat (3) @(negedge clk);
    live(3, 1'b0, "idle oscillator runs");
    tg(0, 30, c);
    chkn(c, 0, 0, "main with cpu off");
    @(posedge clk);
    periph <= 1'b1;
    live(3, 1'b1, "request ignored");
    wr(CGEN_OFS_CTRL2, 32'h10);
    repeat (2) @(negedge clk);
    chk1(dc_gen_on, 1'b0, "generator still on");
    live(3, 1'b0, "oscillator without generator");
    wr(CGEN_OFS_CTRL2, 32'h0);
    cpu_off <= 1'b0;
    periph <= 1'b0;
    repeat (2) @(negedge clk);
    chk1(dc_gen_on, 1'b1, "generator stays off");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_modes();
    t_failsafe();
    t_events();
    t_disable();
    t_routes();
    t_osc();
    t_dco();
    test_done();
  end
endmodule
`default_nettype wire
